// File: core/nvram_cmd_status.sv
// command decoder, status register and write latch of a serial nvram
// assumes the host serial clock is unrelated to clock; cs_n is sampled via sync
`timescale 1ns/1ps
module nvram_cmd_status (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  input  wire logic        write_guard_n,
  input  wire logic        save_busy,
  input  wire logic        restore_busy,
  input  wire logic [16:0] probe_addr,
  output logic             so,
  output logic             so_oe,
  output logic [7:0]       status_out,
  output logic             array_read_start,
  output logic             array_write_start,
  output logic             save_start,
  output logic             restore_start,
  output logic             auto_save_enable,
  output logic             probe_guarded,
  output logic             spi_mode3,
  output nvcmd_pkg::power_mode_t power_mode
);
  import nvcmd_pkg::*;

  logic [7:0] opcode;
  logic [7:0] data_byte;
  logic       data_toggle;
  logic       opcode_toggle;
  logic       so_link;
  logic       so_oe_link;
  logic       cs_n_sync;
  logic       sel_sync;
  logic       op_tog_sync;
  logic       dat_tog_sync;
  logic       sck_sync;
  logic       cs_n_prev_reg;
  logic       op_tog_prev_reg;
  logic       dat_tog_prev_reg;
  logic [7:0] status_reg;
  logic [7:0] frame_op_reg;
  logic       frame_valid_reg;
  logic       latch_at_start_reg;
  logic       frame_grant_reg;
  logic       status_write_done_reg;
  logic       busy;
  logic       frame_end;
  logic       op_event;
  logic       dat_event;
  logic       guard_pin_low;
  logic       is_write_class;

  assign busy = save_busy | restore_busy;

  serial_shifter u_shift (
    .sck           (sck),
    .cs_n          (cs_n),
    .si            (si),
    .status_snap   (status_out),
    .so            (so_link),
    .so_oe         (so_oe_link),
    .opcode        (opcode),
    .data_byte     (data_byte),
    .data_toggle   (data_toggle),
    .opcode_toggle (opcode_toggle)
  );

  // select and guard pin cross inverted: the synchroniser resets to zero,
  // which must read as the idle pin level or a false select follows reset
  sync_bit u_sync_cs (
    .clock     (clock),
    .reset     (reset),
    .in_level  (~cs_n),
    .out_level (sel_sync)
  );

  assign cs_n_sync = ~sel_sync;

  sync_bit u_sync_op (
    .clock     (clock),
    .reset     (reset),
    .in_level  (opcode_toggle),
    .out_level (op_tog_sync)
  );

  sync_bit u_sync_dat (
    .clock     (clock),
    .reset     (reset),
    .in_level  (data_toggle),
    .out_level (dat_tog_sync)
  );

  sync_bit u_sync_sck (
    .clock     (clock),
    .reset     (reset),
    .in_level  (sck),
    .out_level (sck_sync)
  );

  sync_bit u_sync_wg (
    .clock     (clock),
    .reset     (reset),
    .in_level  (~write_guard_n),
    .out_level (guard_pin_low)
  );

  // toggles reset to zero on deselect, so edges are compared each cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cs_n_prev_reg    <= 1'b1;
      op_tog_prev_reg  <= 1'b0;
      dat_tog_prev_reg <= 1'b0;
    end else begin
      cs_n_prev_reg    <= cs_n_sync;
      op_tog_prev_reg  <= op_tog_sync;
      dat_tog_prev_reg <= dat_tog_sync;
    end
  end

  assign frame_end = cs_n_sync & ~cs_n_prev_reg;
  assign op_event  = (op_tog_sync != op_tog_prev_reg) & ~cs_n_sync;
  assign dat_event = (dat_tog_sync != dat_tog_prev_reg) & ~cs_n_sync;

  // opcode is stable in the link domain once the toggle has crossed
  always_comb begin
    is_write_class = 1'b0;
    unique case (frame_op_reg)
      OP_ARRAY_WRITE, OP_STATUS_WRITE, OP_SAVE, OP_RESTORE,
      OP_AUTO_SAVE_ON, OP_AUTO_SAVE_OFF: is_write_class = 1'b1;
      default: is_write_class = 1'b0;
    endcase
  end

  // frame capture: opcode decode and write latch gating
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_op_reg       <= 8'h00;
      frame_valid_reg    <= 1'b0;
      latch_at_start_reg <= 1'b0;
    end else if (frame_end) begin
      frame_valid_reg <= 1'b0;
    end else if (op_event && !frame_valid_reg) begin
      frame_op_reg       <= opcode;
      frame_valid_reg    <= 1'b1;
      latch_at_start_reg <= status_reg[WRITE_LATCH_BIT];
    end
  end

  // grant follows capture by one cycle and drops while busy; denied frames do nothing, except that a status read still drives so
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_grant_reg <= 1'b0;
    end else if (frame_end) begin
      frame_grant_reg <= 1'b0;
    end else begin
      frame_grant_reg <= frame_valid_reg & (~is_write_class | latch_at_start_reg) & ~busy;
    end
  end

  // start pulses for neighbouring engines
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      array_read_start  <= 1'b0;
      array_write_start <= 1'b0;
      save_start        <= 1'b0;
      restore_start     <= 1'b0;
    end else begin
      array_read_start  <= op_event & ~frame_valid_reg & (opcode == OP_ARRAY_READ) & ~busy;
      array_write_start <= op_event & ~frame_valid_reg & (opcode == OP_ARRAY_WRITE)
                           & status_reg[WRITE_LATCH_BIT] & ~busy;
      // save and restore start when the frame closes
      save_start    <= frame_end & frame_grant_reg & (frame_op_reg == OP_SAVE);
      restore_start <= frame_end & frame_grant_reg & (frame_op_reg == OP_RESTORE);
    end
  end

  // auto save enable, kept as a level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      auto_save_enable <= 1'b0;
    end else if (frame_end && frame_grant_reg) begin
      if (frame_op_reg == OP_AUTO_SAVE_ON) begin
        auto_save_enable <= 1'b1;
      end else if (frame_op_reg == OP_AUTO_SAVE_OFF) begin
        auto_save_enable <= 1'b0;
      end
    end
  end

  // status write: only the first data byte counts
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_write_done_reg <= 1'b0;
    end else if (frame_end) begin
      status_write_done_reg <= 1'b0;
    end else if (dat_event && frame_grant_reg && frame_op_reg == OP_STATUS_WRITE) begin
      status_write_done_reg <= 1'b1;
    end
  end

  // stored bits; nonvolatile copy lives in the save engine
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_reg <= STATUS_RESET;
    end else begin
      if (dat_event && frame_grant_reg && frame_op_reg == OP_STATUS_WRITE
          && !status_write_done_reg
          && !(status_reg[PIN_GUARD_BIT] && guard_pin_low)) begin
        status_reg[PIN_GUARD_BIT] <= data_byte[PIN_GUARD_BIT];
        status_reg[GUARD_HI_BIT]  <= data_byte[GUARD_HI_BIT];
        status_reg[GUARD_LO_BIT]  <= data_byte[GUARD_LO_BIT];
      end
      status_reg[6:4] <= STATUS_RESET[6:4];
      // busy flag follows the engines and no status write reaches it
      status_reg[BUSY_BIT] <= busy;
      if (frame_end && frame_grant_reg) begin
        if (frame_op_reg == OP_WRITE_LATCH_SET) begin
          status_reg[WRITE_LATCH_BIT] <= 1'b1;
        end else if (frame_op_reg == OP_WRITE_LATCH_CLEAR || is_write_class) begin
          status_reg[WRITE_LATCH_BIT] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_out <= STATUS_RESET;
    end else begin
      status_out <= status_reg;
    end
  end

  // mode is the clock level seen while the frame opens
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      spi_mode3 <= 1'b0;
    end else if (!cs_n_sync && cs_n_prev_reg) begin
      spi_mode3 <= sck_sync;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      probe_guarded <= 1'b0;
    end else begin
      probe_guarded <= addr_guarded({status_reg[GUARD_HI_BIT], status_reg[GUARD_LO_BIT]},
                                    probe_addr);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      power_mode <= pm_standby;
    end else if (!cs_n_sync) begin
      power_mode <= pm_active;
    end else if (busy) begin
      power_mode <= pm_busy;
    end else begin
      power_mode <= pm_standby;
    end
  end

  // serial output crosses only as a pin; decoded by the link end itself
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      so    <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so    <= so_link;
      so_oe <= so_oe_link;
    end
  end
endmodule

// File: core/nvcmd_pkg.sv
// constants shared by the serial nvram command and status block
// assumes one system clock domain plus the host serial clock
package nvcmd_pkg;
  localparam logic [7:0] OP_WRITE_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ       = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE      = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ        = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE       = 8'h02;
  localparam logic [7:0] OP_SAVE              = 8'h3c;
  localparam logic [7:0] OP_RESTORE           = 8'h60;
  localparam logic [7:0] OP_AUTO_SAVE_ON      = 8'h59;
  localparam logic [7:0] OP_AUTO_SAVE_OFF     = 8'h19;
  localparam int PIN_GUARD_BIT  = 7;
  localparam int GUARD_HI_BIT   = 3;
  localparam int GUARD_LO_BIT   = 2;
  localparam int WRITE_LATCH_BIT = 1;
  localparam int BUSY_BIT       = 0;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h8c;
  localparam logic [7:0] STATUS_RESET      = 8'h00;
  localparam logic [16:0] GUARD_L1_BASE = 17'h18000;
  localparam logic [16:0] GUARD_L2_BASE = 17'h10000;

  typedef enum logic [1:0] {
    cmd_none,
    cmd_latch_set,
    cmd_latch_clear,
    cmd_status_write
  } cmd_kind_t;

  typedef enum logic [1:0] {
    pm_standby = 2'b00,
    pm_active  = 2'b01,
    pm_busy    = 2'b11
  } power_mode_t;

  function automatic logic addr_guarded(input logic [1:0] level, input logic [16:0] addr);
    unique case (level)
      2'b00: addr_guarded = 1'b0;
      2'b01: addr_guarded = addr >= GUARD_L1_BASE;
      2'b10: addr_guarded = addr >= GUARD_L2_BASE;
      2'b11: addr_guarded = 1'b1;
    endcase
  endfunction
endpackage

// File: core/sync_bit.sv
// two-flop level synchroniser
// assumes the input is a level from another clock domain
`timescale 1ns/1ps
module sync_bit (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic in_level,
  output logic      out_level
);
  logic meta_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_reg  <= 1'b0;
      out_level <= 1'b0;
    end else begin
      meta_reg  <= in_level;
      out_level <= meta_reg;
    end
  end
endmodule

// File: core/serial_shifter.sv
// serial link end: shifts opcode and data bytes on the host serial clock
// assumes mode 0 or 3: input on rising edges, output on falling edges
`timescale 1ns/1ps
module serial_shifter (
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic [7:0] status_snap,
  output logic            so,
  output logic            so_oe,
  output logic [7:0]      opcode,
  output logic [7:0]      data_byte,
  output logic            data_toggle,
  output logic            opcode_toggle
);
  import nvcmd_pkg::*;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       have_op_reg;
  logic       reading_reg;
  logic [7:0] out_reg;
  logic [2:0] out_cnt_reg;
  logic [7:0] shift_next;

  assign shift_next = {shift_reg[6:0], si};

  // cs_n as async reset: the serial clock may stop between frames
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
      have_op_reg <= 1'b0;
    end else begin
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7 && !have_op_reg) begin
        have_op_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      opcode        <= 8'h00;
      data_byte     <= 8'h00;
      opcode_toggle <= 1'b0;
      data_toggle   <= 1'b0;
    end else if (bit_cnt_reg == 3'h7) begin
      if (!have_op_reg) begin
        opcode        <= shift_next;
        opcode_toggle <= ~opcode_toggle;
      end else begin
        data_byte   <= shift_next;
        data_toggle <= ~data_toggle;
      end
    end
  end

  // output on falling edges, msb first; only the status read drives so
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      reading_reg <= 1'b0;
      out_reg     <= 8'h00;
      out_cnt_reg <= 3'h0;
      so          <= 1'b0;
      so_oe       <= 1'b0;
    end else if (have_op_reg && opcode == OP_STATUS_READ) begin
      reading_reg <= 1'b1;
      so_oe       <= 1'b1;
      if (!reading_reg || out_cnt_reg == 3'h0) begin
        so          <= status_snap[7];
        out_reg     <= {status_snap[6:0], 1'b0};
        out_cnt_reg <= 3'h7;
      end else begin
        so          <= out_reg[7];
        out_reg     <= {out_reg[6:0], 1'b0};
        out_cnt_reg <= out_cnt_reg - 3'h1;
      end
    end
  end
endmodule

// File: bench/nvram_cmd_status_asserts.sv
// port checker for the nvram command and status block
// assumes outputs registered on clock, reset async high
`timescale 1ns/1ps
module nvram_cmd_status_chk
  import nvcmd_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        cs_n,
  input wire logic        save_busy,
  input wire logic        restore_busy,
  input wire logic [16:0] probe_addr,
  input wire logic        so_oe,
  input wire logic [7:0]  status_out,
  input wire logic        probe_guarded,
  input wire logic        array_write_start,
  input wire logic        save_start,
  input wire logic        spi_mode3,
  input wire power_mode_t power_mode
);
  logic exp_g;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // taken from the visible status image, so only checked once it has settled
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      exp_g <= 1'b0;
    end else begin
      exp_g <= (&status_out[3:2]) || (status_out[3] && probe_addr >= GUARD_L2_BASE)
               || (status_out[2] && probe_addr >= GUARD_L1_BASE);
    end
  end
  a_busy_bit_set: assert property ((save_busy || restore_busy) [*4] |-> status_out[0])
    else $error("busy bit low while an engine is busy");
  a_spare_bits_zero: assert property (status_out[6:4] == 3'h0)
    else $error("spare status bits not zero");
  a_active_when_sel: assert property ((!cs_n) [*5] |-> power_mode == pm_active)
    else $error("not active while selected");
  a_standby_idle: assert property ((cs_n && !save_busy && !restore_busy) [*5]
      |-> power_mode == pm_standby)
    else $error("not standby while idle");
  a_out_off_idle: assert property (cs_n [*5] |-> !so_oe)
    else $error("serial output driven while deselected");
  a_probe_level: assert property (($stable(status_out[3:2])) [*3]
      |-> probe_guarded == exp_g)
    else $error("guard result does not match level");
  a_latch_at_desel: assert property ($changed(status_out[1]) |-> cs_n)
    else $error("write latch moved while selected");
  a_write_latched: assert property (array_write_start |-> status_out[1])
    else $error("array write started with latch clear");
  a_save_single: assert property (save_start |=> !save_start)
    else $error("save pulse longer than one cycle");
  a_mode_hold: assert property ((!cs_n) [*6] |-> $stable(spi_mode3))
    else $error("mode changed within a frame");
endmodule
bind nvram_cmd_status nvram_cmd_status_chk chk (
  .clock(clock),
  .reset(reset),
  .cs_n(cs_n),
  .save_busy(save_busy),
  .restore_busy(restore_busy),
  .probe_addr(probe_addr),
  .so_oe(so_oe),
  .status_out(status_out),
  .probe_guarded(probe_guarded),
  .array_write_start(array_write_start),
  .save_start(save_start),
  .spi_mode3(spi_mode3),
  .power_mode(power_mode)
);

// File: bench/spi_host.sv
// host serial master model, 64 ns serial clock, still outside frames
// assumes the device drives so only while so_oe is high
`timescale 1ns/1ps
module spi_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // one opcode per select, msb first, fresh select fall each time
  task automatic frame(input logic m3, input logic [15:0] tx, input int nb,
                       output logic [7:0] rx);
    sck = m3;
    #40 cs_n = 1'b0;
    for (int i = 15; i >= 16 - nb * 8; i--) begin
      #32 sck = 1'b0;
      si = tx[i];
      #32 sck = 1'b1;
      rx = {rx[6:0], so_oe ? so : 1'bx};
    end
    #32 sck = m3;
    cs_n = 1'b1;
    // a released line must not look like it holds the last bit
    si = ~si;
    #120;
  endtask
endmodule

// File: bench/tb_nvram_cmd_status.sv
// self-checking bench for the nvram command and status block
// assumes spi_host as far side and the bound port checker
`timescale 1ns/1ps
module tb_nvram_cmd_status;
  import nvcmd_pkg::*;
  logic        clock;
  logic        reset;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        write_guard_n;
  logic        save_busy;
  logic        restore_busy;
  logic [16:0] probe_addr;
  logic        so;
  logic        so_oe;
  logic [7:0]  status_out;
  wire  [3:0]  pulses;
  logic        auto_save_enable;
  logic        probe_guarded;
  logic        spi_mode3;
  power_mode_t power_mode;
  logic        m3;
  logic [7:0]  rx;
  logic [3:0]  exp_q[$];
  int          errors;
  int          checks;
  logic [7:0]  ops[6] = '{OP_ARRAY_READ, OP_ARRAY_WRITE, OP_SAVE, OP_RESTORE,
                          OP_AUTO_SAVE_ON, OP_AUTO_SAVE_OFF};
  logic [3:0]  pv[6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0};
  logic [16:0] at[6] = '{17'h0ffff, 17'h10000, 17'h17fff, 17'h18000, 17'h1ffff, 17'h00000};
  nvram_cmd_status dut (
    .clock(clock), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si),
    .write_guard_n(write_guard_n), .save_busy(save_busy), .restore_busy(restore_busy),
    .probe_addr(probe_addr), .so(so), .so_oe(so_oe), .status_out(status_out),
    .array_read_start(pulses[3]), .array_write_start(pulses[2]), .save_start(pulses[1]),
    .restore_start(pulses[0]), .auto_save_enable(auto_save_enable),
    .probe_guarded(probe_guarded), .spi_mode3(spi_mode3), .power_mode(power_mode)
  );
  spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // about 4 clocks to cross, so 10 leaves margin
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int nb);
    host.frame(m3, {op, d}, nb, rx);
    repeat (10) @(posedge clock);
    #1;
  endtask
  task automatic wr_status(input logic [7:0] d);
    cmd(OP_WRITE_LATCH_SET, 8'h00, 1);
    cmd(OP_STATUS_WRITE, d, 2);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // pulses are compared against the oldest note as they appear
  always @(negedge clock) begin
    if (pulses !== 4'h0)
      check(pulses, exp_q.size() > 0 ? exp_q.pop_front() : 4'h0);
  end
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    write_guard_n = 1'b1;
    save_busy = 1'b0;
    restore_busy = 1'b0;
    probe_addr = 17'h00000;
    m3 = 1'b0;
    errors = 0;
    checks = 0;
    void'($urandom(56299));
    repeat (10) @(posedge clock);
    #1 reset = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(status_out, STATUS_RESET);
    check(power_mode, pm_standby);
    cmd(OP_STATUS_WRITE, 8'h8c, 2);
    cmd(OP_SAVE, 8'h00, 1);
    cmd(OP_AUTO_SAVE_ON, 8'h00, 1);
    check(status_out, 8'h00);
    check(auto_save_enable, 1'b0);
    cmd(OP_WRITE_LATCH_SET, 8'h00, 1);
    check(status_out[1], 1'b1);
    cmd(OP_WRITE_LATCH_CLEAR, 8'h00, 1);
    check(status_out[1], 1'b0);
    $display("test latch done");
    m3 = $urandom_range(1, 0) == 1;
    wr_status(8'($urandom) | 8'h8c);
    check(status_out, 8'h8c);
    cmd(OP_STATUS_READ, 8'h00, 2);
    check(rx, 8'h8c);
    check(spi_mode3, m3);
    write_guard_n = 1'b0;
    wr_status(8'h00);
    check(status_out & 8'hfd, 8'h8c);
    write_guard_n = 1'b1;
    wr_status(8'h00);
    check(status_out, 8'h00);
    $display("test status done");
    for (int lv = 0; lv < 4; lv++) begin
      wr_status({4'h0, lv[1:0], 2'b00});
      for (int k = 0; k < 6; k++) begin
        probe_addr = (k < 5) ? at[k] : 17'($urandom);
        repeat (2) @(posedge clock);
        #1;
        check(probe_guarded, lv == 3 || (lv == 2 && probe_addr >= GUARD_L2_BASE)
              || (lv == 1 && probe_addr >= GUARD_L1_BASE));
      end
    end
    $display("test guard done");
    for (int i = 0; i < 6; i++) begin
      m3 = $urandom_range(1, 0) == 1;
      cmd(OP_WRITE_LATCH_SET, 8'h00, 1);
      if (pv[i] != 4'h0)
        exp_q.push_back(pv[i]);
      cmd(ops[i], 8'h00, 1);
      check(status_out[1], i == 0);
      check(auto_save_enable, i == 4);
    end
    $display("test commands done");
    save_busy = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    check(status_out[0], 1'b1);
    check(power_mode, pm_busy);
    save_busy = 1'b0;
    restore_busy = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    check(status_out[0], 1'b1);
    check(power_mode, pm_busy);
    restore_busy = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    check(power_mode, pm_standby);
    cmd(8'h1e, 8'h00, 2);
    check(rx, 8'hxx);
    check(exp_q.size(), 0);
    $display("test busy and unknown done");
    end_of_test();
  end
endmodule
